// File: src/sbar_pkg.sv
// package: register map, field layout and reset values of the buffer admission registers
package sbar_pkg;
	// register indices; byte address is four times the index
	localparam logic [15:0] SBAR_IDX_CFG = 16'h1c00;
	localparam logic [15:0] SBAR_IDX_DROP = 16'h1c01;
	localparam logic [15:0] SBAR_IDX_PAUSE = 16'h1c02;
	localparam logic [15:0] SBAR_IDX_RESUME = 16'h1c03;
	localparam logic [15:0] SBAR_IDX_FLOOD = 16'h1c04;
	localparam logic [15:0] SBAR_IDX_CNT0 = 16'h1c05;
	localparam int SBAR_ADDR_W = 18;
	// configuration field positions
	localparam int SBAR_CFG_TEST_BIT = 6;
	localparam int SBAR_CFG_FIXED_BIT = 5;
	localparam int SBAR_CFG_PACE_LSB = 2;
	localparam int SBAR_CFG_YELLOW_BIT = 1;
	localparam int SBAR_CFG_RED_BIT = 0;
	localparam int SBAR_CFG_W = 7;
	localparam int SBAR_LOW_LSB = 8;
	localparam int SBAR_HIGH_LSB = 0;
	// reset values
	localparam logic [6:0] SBAR_CFG_RST = 7'h00;
	localparam logic [7:0] SBAR_DROP_LOW_RST = 8'h49;
	localparam logic [7:0] SBAR_DROP_HIGH_RST = 8'h64;
	localparam logic [7:0] SBAR_PAUSE_LOW_RST = 8'h21;
	localparam logic [7:0] SBAR_PAUSE_HIGH_RST = 8'h3c;
	localparam logic [7:0] SBAR_RESUME_LOW_RST = 8'h03;
	localparam logic [7:0] SBAR_RESUME_HIGH_RST = 8'h07;
	localparam logic [7:0] SBAR_FLOOD_RST = 8'h31;
	localparam logic [31:0] SBAR_CNT_RST = 32'h00000000;
	localparam logic [31:0] SBAR_CNT_TEST_VAL = 32'h07fffffc;
	localparam logic [31:0] SBAR_CNT_MAX = 32'hffffffff;
	// buffer accounting
	localparam int SBAR_BUF_BYTES = 128;
	localparam logic [7:0] SBAR_ACTIVE_BUFS = 8'h24;
	localparam int SBAR_PORTS = 3;
	localparam logic [15:0] SBAR_PAUSE_RESUME_VAL = 16'h0001;
	typedef enum logic [1:0] {SBAR_IDLE = 2'b00, SBAR_ACCESS = 2'b01} sbar_apb_state_type;
endpackage

// File: src/sbar_port_if.sv
// interface: per-port admission limits passed from the register core to the port checker
`timescale 1ns/1ps
interface sbar_port_if;
	logic [7:0] drop_lvl;
	logic [7:0] pause_lvl;
	logic [7:0] resume_lvl;
	logic [7:0] used;
	logic active;
	logic over_drop;
	logic at_pause;
	logic at_resume;
	modport core (output drop_lvl, output pause_lvl, output resume_lvl, output used,
		input active, input over_drop, input at_pause, input at_resume);
	modport chk (input drop_lvl, input pause_lvl, input resume_lvl, input used,
		output active, output over_drop, output at_pause, output at_resume);
endinterface

// File: src/sbar_port_chk.sv
// port checker: compares one port's buffer usage against its current limits
`timescale 1ns/1ps
module sbar_port_chk
	import sbar_pkg::*;
(
	sbar_port_if.chk p
);
	// thresholds are whole 128-byte buffers, so compare raw counts
	assign p.active = (p.used >= SBAR_ACTIVE_BUFS);
	assign p.over_drop = (p.used >= p.drop_lvl);
	assign p.at_pause = (p.used >= p.pause_lvl);
	assign p.at_resume = (p.used <= p.resume_lvl);
endmodule

// File: src/sbar_regs.sv
// buffer admission register bank: apb slave, limits selection, flow control and port 0 drop count
//
// Summary of operation
// - with counter test set, reading a clear-on-read counter loads the test value
// - queue servicing bit set gives fixed priority, clear gives weighted round robin
// - three pacing enable bits drive ports 2, 1 and 0 from high to low
// - yellow drop set: over committed burst packets go yellow, may be randomly discarded
// - red drop set: over excess burst packets go red and are always discarded
// - all buffer levels count 128-byte buffers
// - a port is active when 36 or more buffers are in use
// - two or three active ports limit each ingress port to the low drop level
// - one active port limits each ingress port to the high drop level
// - pause or backpressure at pause level, low or high field by active count
// - pause value 1 sent at resume level, low or high field by active count
// - flood traffic buffers are capped at the broadcast drop level
// - port 0 buffer manager drops increment a 32-bit counter
// - port 0 drop counter saturates at all ones and clears when read with counter test clear
`timescale 1ns/1ps
module sbar_regs
	import sbar_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [SBAR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [23:0] port_used,
	input wire logic [7:0] flood_used,
	input wire logic [2:0] pkt_valid,
	input wire logic [2:0] pkt_flood,
	input wire logic [2:0] pkt_yellow,
	input wire logic [2:0] pkt_red,
	input wire logic [2:0] pkt_rand_drop,
	output logic [2:0] pkt_drop,
	output logic [2:0] pkt_mark_yellow,
	output logic [2:0] pkt_mark_red,
	output logic [2:0] pause_req,
	output logic [2:0] pause_tx,
	output logic [15:0] pause_value,
	output logic fixed_priority,
	output logic [2:0] egress_pace_en
);
	logic [6:0] cfg_q;
	logic [15:0] drop_q;
	logic [15:0] pause_q;
	logic [15:0] resume_q;
	logic [7:0] flood_q;
	logic [31:0] cnt0_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	sbar_apb_state_type state_q;
	logic [2:0] act_vec;
	logic [2:0] over_drop;
	logic [2:0] at_pause;
	logic [2:0] at_resume;
	logic [1:0] act_cnt_q;
	logic multi_act;
	logic [7:0] drop_sel;
	logic [7:0] pause_sel;
	logic [7:0] resume_sel;
	logic [2:0] paused_q;
	logic [2:0] drop_d;
	logic [2:0] yel_d;
	logic [2:0] red_d;
	logic flood_full;
	logic [2:0] pause_req_q;
	logic [2:0] pause_tx_q;
	logic [15:0] pause_val_q;
	logic [2:0] drop_q3;
	logic [2:0] yel_q;
	logic [2:0] red_q;
	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic [15:0] widx;
	logic hit;
	logic sel_cfg;
	logic sel_drop;
	logic sel_pause;
	logic sel_resume;
	logic sel_flood;
	logic sel_cnt0;
	logic [31:0] rd_mux;

	// apb decode: byte address is four times the register index, low two bits ignored
	assign widx = 16'(paddr[SBAR_ADDR_W-1:2]);
	assign acc = psel & penable & (state_q == SBAR_ACCESS);
	assign wr_acc = acc & pwrite;
	assign rd_acc = acc & ~pwrite;
	assign hit = (widx >= SBAR_IDX_CFG) && (widx <= SBAR_IDX_CNT0);
	assign sel_cfg = (widx == SBAR_IDX_CFG);
	assign sel_drop = (widx == SBAR_IDX_DROP);
	assign sel_pause = (widx == SBAR_IDX_PAUSE);
	assign sel_resume = (widx == SBAR_IDX_RESUME);
	assign sel_flood = (widx == SBAR_IDX_FLOOD);
	assign sel_cnt0 = (widx == SBAR_IDX_CNT0);

	// one wait state: setup, access, then answer in the following access cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_q <= SBAR_IDLE;
		else if (psel & ~penable)
			state_q <= SBAR_ACCESS;
		else if (pready_q | ~psel)
			state_q <= SBAR_IDLE;
	end

	// pready is a one-cycle pulse; the access state drops with it, so a held request is not answered twice
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pready_q <= 1'b0;
		else
			pready_q <= acc & ~pready_q;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pslverr_q <= 1'b0;
		else
			pslverr_q <= acc & ~pready_q & ~hit;
	end

	always_comb
	begin
		rd_mux = 32'h00000000;
		case (widx)
			SBAR_IDX_CFG: rd_mux = {25'h0000000, cfg_q};
			SBAR_IDX_DROP: rd_mux = {16'h0000, drop_q};
			SBAR_IDX_PAUSE: rd_mux = {16'h0000, pause_q};
			SBAR_IDX_RESUME: rd_mux = {16'h0000, resume_q};
			SBAR_IDX_FLOOD: rd_mux = {24'h000000, flood_q};
			SBAR_IDX_CNT0: rd_mux = cnt0_q;
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prdata_q <= 32'h00000000;
		else if (rd_acc & ~pready_q)
			prdata_q <= rd_mux;
	end

	// writes and read clears land at the edge where the master samples pready high and ends the transfer
	wire wr_now = wr_acc & pready_q;
	wire rd_now = rd_acc & pready_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cfg_q <= SBAR_CFG_RST;
		else if (wr_now && sel_cfg && pstrb[0])
			cfg_q <= pwdata[SBAR_CFG_W-1:0];
	end

	// one process per threshold register; only byte lanes 0 and 1 carry fields
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			drop_q <= {SBAR_DROP_LOW_RST, SBAR_DROP_HIGH_RST};
		else if (wr_now && sel_drop)
		begin
			for (int b = 0; b < 2; b++)
			begin
				if (pstrb[b])
					drop_q[b*8 +: 8] <= pwdata[b*8 +: 8];
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pause_q <= {SBAR_PAUSE_LOW_RST, SBAR_PAUSE_HIGH_RST};
		else if (wr_now && sel_pause)
		begin
			for (int b = 0; b < 2; b++)
			begin
				if (pstrb[b])
					pause_q[b*8 +: 8] <= pwdata[b*8 +: 8];
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			resume_q <= {SBAR_RESUME_LOW_RST, SBAR_RESUME_HIGH_RST};
		else if (wr_now && sel_resume)
		begin
			for (int b = 0; b < 2; b++)
			begin
				if (pstrb[b])
					resume_q[b*8 +: 8] <= pwdata[b*8 +: 8];
			end
		end
	end

	// the flood cap lives in lane 0; the upper lanes are reserved and read back as zero
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			flood_q <= SBAR_FLOOD_RST;
		else if (wr_now && sel_flood && pstrb[0])
			flood_q <= pwdata[7:0];
	end

	// per-port threshold comparison
	genvar g;
	generate
		for (g = 0; g < SBAR_PORTS; g++)
		begin : gen_port
			sbar_port_if pif ();
			assign pif.drop_lvl = drop_sel;
			assign pif.pause_lvl = pause_sel;
			assign pif.resume_lvl = resume_sel;
			assign pif.used = port_used[g*8 +: 8];
			assign act_vec[g] = pif.active;
			assign over_drop[g] = pif.over_drop;
			assign at_pause[g] = pif.at_pause;
			assign at_resume[g] = pif.at_resume;
			sbar_port_chk u_chk (
				.p(pif.chk)
			);
		end
	endgenerate

	// registered count keeps the threshold choice glitch-free across usage changes
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			act_cnt_q <= 2'd0;
		else
			act_cnt_q <= 2'(act_vec[0]) + 2'(act_vec[1]) + 2'(act_vec[2]);
	end

	assign multi_act = (act_cnt_q >= 2'd2);
	assign drop_sel = multi_act ? drop_q[SBAR_LOW_LSB +: 8] : drop_q[SBAR_HIGH_LSB +: 8];
	assign pause_sel = multi_act ? pause_q[SBAR_LOW_LSB +: 8] : pause_q[SBAR_HIGH_LSB +: 8];
	assign resume_sel = multi_act ? resume_q[SBAR_LOW_LSB +: 8] : resume_q[SBAR_HIGH_LSB +: 8];
	assign flood_full = (flood_used >= flood_q);

	// admission decision per arriving packet
	always_comb
	begin
		for (int i = 0; i < SBAR_PORTS; i++)
		begin
			yel_d[i] = pkt_valid[i] & pkt_yellow[i] & cfg_q[SBAR_CFG_YELLOW_BIT];
			red_d[i] = pkt_valid[i] & pkt_red[i] & cfg_q[SBAR_CFG_RED_BIT];
			drop_d[i] = pkt_valid[i] & (over_drop[i] | red_d[i] | (yel_d[i] & pkt_rand_drop[i])
				| (pkt_flood[i] & flood_full));
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			drop_q3 <= 3'b000;
			yel_q <= 3'b000;
			red_q <= 3'b000;
		end
		else
		begin
			drop_q3 <= drop_d;
			yel_q <= yel_d;
			red_q <= red_d;
		end
	end

	// flow control: pause once at pause level, hold until resume level, then send value 1
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			paused_q <= 3'b000;
			pause_tx_q <= 3'b000;
			pause_val_q <= 16'h0000;
		end
		else
		begin
			pause_tx_q <= 3'b000;
			pause_val_q <= 16'h0000;
			for (int i = 0; i < SBAR_PORTS; i++)
			begin
				if (!paused_q[i] && at_pause[i])
				begin
					paused_q[i] <= 1'b1;
					pause_tx_q[i] <= 1'b1;
				end
				else if (paused_q[i] && at_resume[i])
				begin
					paused_q[i] <= 1'b0;
					pause_tx_q[i] <= 1'b1;
					pause_val_q <= SBAR_PAUSE_RESUME_VAL;
				end
			end
		end
	end

	// pause_req follows the paused state one cycle later, as a level for the port's transmitter
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pause_req_q <= 3'b000;
		else
			pause_req_q <= paused_q;
	end

	// port 0 drop counter: a drop in the read cycle is counted as 1 after the clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt0_q <= SBAR_CNT_RST;
		else if (rd_now && sel_cnt0)
		begin
			if (cfg_q[SBAR_CFG_TEST_BIT])
				cnt0_q <= SBAR_CNT_TEST_VAL;
			else
				cnt0_q <= drop_d[0] ? 32'h00000001 : SBAR_CNT_RST;
		end
		else if (drop_d[0] && cnt0_q != SBAR_CNT_MAX)
			cnt0_q <= cnt0_q + 32'h00000001;
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign pkt_drop = drop_q3;
	assign pkt_mark_yellow = yel_q;
	assign pkt_mark_red = red_q;
	assign pause_req = pause_req_q;
	assign pause_tx = pause_tx_q;
	assign pause_value = pause_val_q;
	assign fixed_priority = cfg_q[SBAR_CFG_FIXED_BIT];
	assign egress_pace_en = cfg_q[SBAR_CFG_PACE_LSB +: 3];
endmodule

// File: verification/sbar_regs_monitor.sv
// checker: apb timing, packet answers and flow control signalling of the admission register bank
`timescale 1ns/1ps
module sbar_regs_monitor
	import sbar_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [SBAR_ADDR_W-1:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [2:0] pkt_valid,
	input wire logic [2:0] pkt_drop,
	input wire logic [2:0] pkt_mark_red,
	input wire logic [2:0] pause_tx,
	input wire logic [15:0] pause_value,
	input wire logic fixed_priority,
	input wire logic [2:0] egress_pace_en
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// only the six words from 0x7000 up are decoded
	wire bad = paddr < 18'h07000 || paddr > 18'h07014 || paddr[1:0] != 2'b00;
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable;
	endsequence
	a_ready_when_due: assert property (setup_s ##1 access_s |=> pready) else $error("pready not two cycles after setup");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	a_ready_in_access: assert property (pready |-> access_s) else $error("pready outside access phase");
	a_err_unmapped: assert property (pready |-> pslverr == bad) else $error("pslverr disagrees with address");
	a_drop_after_valid: assert property (pkt_drop != 3'b000 |-> (pkt_drop & ~$past(pkt_valid)) == 3'b000)
		else $error("pkt_drop without packet");
	a_red_always_drops: assert property ((pkt_mark_red & ~pkt_drop) == 3'b000) else $error("red packet kept");
	a_resume_value: assert property (pause_value != 16'h0000 |-> pause_tx != 3'b000 && pause_value == 16'h0001)
		else $error("pause value wrong");
	a_cfg_by_write: assert property ($changed({fixed_priority, egress_pace_en}) |->
		$past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2) || $past(psel && penable && pwrite, 3))
		else $error("config outputs changed without write");
endmodule
bind sbar_regs sbar_regs_monitor u_mon (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt_drop(pkt_drop),
	.pkt_mark_red(pkt_mark_red), .pause_tx(pause_tx), .pause_value(pause_value), .fixed_priority(fixed_priority),
	.egress_pace_en(egress_pace_en));

// File: verification/sbar_regs_tb.sv
// testbench: register access, packet admission and flow control of the admission register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch %s expected %h seen %h", n, e, g); end end
module sbar_regs_tb
	import sbar_pkg::*;
;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, fixed_priority, err;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] port_used;
	logic [7:0] flood_used;
	logic [2:0] pkt_valid, pkt_flood, pkt_yellow, pkt_red, pkt_rand_drop;
	logic [2:0] pkt_drop, pkt_mark_yellow, pkt_mark_red, pause_req, pause_tx, egress_pace_en;
	logic [15:0] pause_value;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	sbar_regs dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port_used(port_used), .flood_used(flood_used), .pkt_valid(pkt_valid), .pkt_flood(pkt_flood),
		.pkt_yellow(pkt_yellow), .pkt_red(pkt_red), .pkt_rand_drop(pkt_rand_drop), .pkt_drop(pkt_drop),
		.pkt_mark_yellow(pkt_mark_yellow), .pkt_mark_red(pkt_mark_red), .pause_req(pause_req),
		.pause_tx(pause_tx), .pause_value(pause_value), .fixed_priority(fixed_priority),
		.egress_pace_en(egress_pace_en));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// the run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			close_out;
		end
	end
	task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input logic [15:0] idx, input logic [31:0] e);
		apb(1'b0, idx, 32'h0);
		`CHK($sformatf("register %h", idx), e, rd)
	endtask
	// attribute order: flood, yellow, red, random discard
	task pkt(input int p, input logic [3:0] a, input logic e);
		repeat (2) @(posedge clk);
		pkt_valid[p] <= 1'b1;
		{pkt_flood[p], pkt_yellow[p], pkt_red[p], pkt_rand_drop[p]} <= a;
		@(posedge clk);
		pkt_valid <= 3'b000;
		#1 `CHK("pkt_drop", e, pkt_drop[p])
	endtask
	task pause_wait(input logic [15:0] v);
		int n;
		n = 0;
		while (pause_tx[0] !== 1'b1 && n < 8)
		begin
			@(posedge clk);
			#1 n++;
		end
		`CHK("pause_tx", 1'b1, pause_tx[0])
		`CHK("pause_value", v, pause_value)
	endtask
	initial
	begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, port_used, flood_used} = '0;
		{pkt_valid, pkt_flood, pkt_yellow, pkt_red, pkt_rand_drop} = '0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdc(SBAR_IDX_CFG, 32'h0);
		rdc(SBAR_IDX_DROP, 32'h4964);
		rdc(SBAR_IDX_PAUSE, 32'h213c);
		rdc(SBAR_IDX_RESUME, 32'h0307);
		rdc(SBAR_IDX_FLOOD, 32'h31);
		rdc(SBAR_IDX_CNT0, 32'h0);
		apb(1'b1, 16'h1c06, 32'hffffffff);
		`CHK("pslverr", 1'b1, err)
		$display("test reset values done");
		apb(1'b1, SBAR_IDX_CFG, 32'h34);
		rdc(SBAR_IDX_CFG, 32'h34);
		`CHK("fixed_priority", 1'b1, fixed_priority)
		`CHK("egress_pace_en", 3'b101, egress_pace_en)
		apb(1'b1, SBAR_IDX_CFG, 32'hffffff0b);
		rdc(SBAR_IDX_CFG, 32'h0b);
		`CHK("fixed_priority", 1'b0, fixed_priority)
		`CHK("egress_pace_en", 3'b010, egress_pace_en)
		$display("test configuration done");
		pkt(0, 4'b0010, 1'b1);
		`CHK("pkt_mark_red", 1'b1, pkt_mark_red[0])
		pkt(0, 4'b0101, 1'b1);
		pkt(0, 4'b0100, 1'b0);
		`CHK("pkt_mark_yellow", 1'b1, pkt_mark_yellow[0])
		pkt(1, 4'b0010, 1'b1);
		rdc(SBAR_IDX_CNT0, 32'h2);
		rdc(SBAR_IDX_CNT0, 32'h0);
		apb(1'b1, SBAR_IDX_CFG, 32'h41);
		pkt(0, 4'b0010, 1'b1);
		rdc(SBAR_IDX_CNT0, 32'h1);
		rdc(SBAR_IDX_CNT0, SBAR_CNT_TEST_VAL);
		$display("test drop counter done");
		port_used <= 24'h00003c;
		pause_wait(16'h0000);
		@(posedge clk);
		#1 `CHK("pause_req", 1'b1, pause_req[0])
		port_used <= 24'h000007;
		pause_wait(16'h0001);
		$display("test flow control done");
		port_used <= 24'h002349;
		pkt(0, 4'b0000, 1'b0);
		port_used <= 24'h002449;
		pkt(0, 4'b0000, 1'b1);
		port_used <= 24'h002448;
		pkt(0, 4'b0000, 1'b0);
		port_used <= 24'h000063;
		pkt(0, 4'b0000, 1'b0);
		port_used <= 24'h000064;
		pkt(0, 4'b0000, 1'b1);
		port_used <= 24'h000000;
		flood_used <= 8'h30;
		pkt(0, 4'b1000, 1'b0);
		flood_used <= 8'h31;
		pkt(0, 4'b1000, 1'b1);
		$display("test admission limits done");
		close_out;
	end
endmodule
